// *** regulator_channel_map.vh ***
// Register offsets, field positions, reset values and codes of the regulator channel bank.
`ifndef REGULATOR_CHANNEL_MAP_VH
`define REGULATOR_CHANNEL_MAP_VH

// ==========================================================================
// Register offsets
`define OFS_A_SLEEP_CTRL 16'h4073
`define OFS_B_MAIN_CTRL 16'h4074
`define OFS_B_ON_CTRL 16'h4075
`define OFS_B_SLEEP_CTRL 16'h4076
`define OFS_IRQ_STATUS 16'h40F0
`define OFS_IRQ_MASK 16'h40F1

// ==========================================================================
// Field positions
`define SLP_SLOT_MSB 15
`define SLP_SLOT_LSB 13
`define SLP_MODE_BIT 8
`define VSEL_MSB 4
`define VSEL_LSB 0
`define ERR_ACT_MSB 15
`define ERR_ACT_LSB 14
`define HWC_SRC_MSB 12
`define HWC_SRC_LSB 11
`define HWC_VPICK_BIT 10
`define HWC_MODE_MSB 9
`define HWC_MODE_LSB 8
`define FLT_BIT 7
`define SWI_BIT 6
`define LP_CLASS_BIT 0
`define ON_MODE_BIT 8
`define IRQ_UV_BIT 0
`define IRQ_SLEEP_BIT 1

// ==========================================================================
// Reset values
`define RST_SLP_SLOT 3'h0
`define RST_SLP_MODE 1'h1
`define RST_VSEL 5'h00
`define RST_ERR_ACT 2'h0
`define RST_HWC_SRC 2'h0
`define RST_HWC_MODE 2'h2
`define RST_FLT 1'h0
`define RST_IRQ_MASK 2'h0

// ==========================================================================
// Codes
`define ACT_IGNORE 2'h0
`define ACT_SHUT_REG 2'h1
`define ACT_SHUT_SYS 2'h2
`define HWC_OFF 2'h0
`define HWC_IN1 2'h1
`define HWC_IN2 2'h2
`define HWC_EITHER 2'h3
`define HMODE_OFF 2'h1
`define HMODE_ON_BIT 2'h3
`define VSEL_FINE_TOP 5'h0E
`define MV_BASE 12'h384
`define MV_FINE_STEP 12'h032
`define MV_COARSE_BASE 12'h6A4
`define MV_COARSE_STEP 12'h064

`endif

// *** sleep_slot_decode.v ***
// Decoder from the sleep timeslot code to a target timeslot and an action.
`timescale 1ns/1ps

module sleep_slot_decode (
  // Code and assignment.
  input wire [2:0] slot_code_i,
  input wire hw_assigned_i,
  // Decoded target.
  output reg [2:0] target_slot_o,
  output reg disable_o
);

  // Transition codes keep the output on; the middle codes turn it off unless hardware owns it.
  always @* begin
    case (slot_code_i)
      3'h0: begin
        target_slot_o = 3'h5;
        disable_o = 1'b0;
      end
      3'h6: begin
        target_slot_o = 3'h3;
        disable_o = 1'b0;
      end
      3'h7: begin
        target_slot_o = 3'h1;
        disable_o = 1'b0;
      end
      default: begin
        target_slot_o = 3'h6 - slot_code_i;
        disable_o = ~hw_assigned_i;
      end
    endcase
  end

endmodule

// *** voltage_code_to_mv.v ***
// Conversion of a 5-bit regulator voltage code to millivolts.
`timescale 1ns/1ps
`include "regulator_channel_map.vh"

module voltage_code_to_mv (
  // Voltage code.
  input wire [4:0] code_i,
  // Output level in millivolts.
  output reg [11:0] mv_o
);

  // Fine 50 mV steps up to 1.6 V, then 100 mV steps from 1.7 V.
  always @* begin
    if (code_i <= `VSEL_FINE_TOP) begin
      mv_o = `MV_BASE + `MV_FINE_STEP * {7'h00, code_i};
    end else begin
      mv_o = `MV_COARSE_BASE + `MV_COARSE_STEP * {7'h00, code_i - 5'h0F};
    end
  end

endmodule

// *** regulator_channel_control_regs.v ***
// Control register bank and control decode for two regulator channels.
`timescale 1ns/1ps
`include "regulator_channel_map.vh"

// Operation
// - Sleep codes 000, 110, 111 apply sleep voltage and mode in slots 5, 3, 1.
// - Sleep codes 001 to 101 disable the regulator in slots 5 down to 1.
// - With a hardware enable assigned, codes 001 to 101 pick the sleep-entry slot.
// - Sleep mode bit 8: 0 normal, 1 low power; resets to 1.
// - Voltage code: 0.9 V in 50 mV steps to 1.6 V, then 100 mV steps.
// - Undervoltage action: ignore, shut down regulator, or whole-system reset.
// - Every undervoltage raises an interrupt whatever the action.
// - Hardware control source: none, input 1, input 2, or either input.
// - Under hardware control bit 10 picks ON or sleep voltage code.
// - Hardware mode: 00 and 10 low power, 01 off, 11 follows ON mode.
// - Bit 7: 0 discharges the disabled output, 1 leaves it floating.
// - Bit 0 picks 50 mA or 20 mA low-power class.
// - ON mode bit 8 selects normal at 0, low power at 1.
module regulator_channel_control_regs (
  // Clock and reset.
  input wire sys_clk_i,
  input wire rst_i,
  // Register port.
  input wire [15:0] addr_i,
  input wire [15:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [15:0] rdata_o,
  // Sleep sequencer.
  input wire sleep_seq_i,
  input wire [2:0] timeslot_i,
  input wire timeslot_stb_i,
  input wire wake_i,
  input wire a_hw_assigned_i,
  // Channel B control inputs.
  input wire hwc1_i,
  input wire hwc2_i,
  input wire b_sw_on_i,
  input wire b_undervoltage_i,
  // Channel A state.
  output reg a_in_sleep_o,
  output reg a_disabled_o,
  output reg a_low_power_o,
  output reg [11:0] a_sleep_mv_o,
  // Channel B state.
  output reg b_enable_o,
  output reg b_low_power_o,
  output reg b_class_20ma_o,
  output reg b_discharge_o,
  output reg [11:0] b_mv_o,
  output reg sys_reset_req_o,
  // Interrupt.
  output reg irq_o
);

  // ==========================================================================
  // Register storage
  reg [2:0] a_slp_slot_ff;
  reg a_slp_mode_ff;
  reg [4:0] a_slp_vsel_ff;
  reg [1:0] b_err_act_ff;
  reg [1:0] b_hwc_src_ff;
  reg b_hwc_vpick_ff;
  reg [1:0] b_hwc_mode_ff;
  reg b_flt_ff;
  reg b_swi_ff;
  reg b_lp_class_ff;
  reg b_on_mode_ff;
  reg [4:0] b_on_vsel_ff;
  reg [4:0] b_slp_vsel_ff;
  reg [1:0] irq_status_ff;
  reg [1:0] irq_mask_ff;
  reg b_shutdown_ff;
  reg a_done_ff;

  // Decoded access strobes.
  wire wr_a_slp;
  wire wr_b_main;
  wire wr_b_on;
  wire wr_b_slp;
  wire wr_mask;
  wire rd_status;

  assign wr_a_slp = wr_i && (addr_i == `OFS_A_SLEEP_CTRL);
  assign wr_b_main = wr_i && (addr_i == `OFS_B_MAIN_CTRL);
  assign wr_b_on = wr_i && (addr_i == `OFS_B_ON_CTRL);
  assign wr_b_slp = wr_i && (addr_i == `OFS_B_SLEEP_CTRL);
  assign wr_mask = wr_i && (addr_i == `OFS_IRQ_MASK);
  assign rd_status = rd_i && (addr_i == `OFS_IRQ_STATUS);

  // ==========================================================================
  // Channel A sleep decode
  wire [2:0] a_target_slot;
  wire a_target_disable;
  wire [11:0] a_mv;

  sleep_slot_decode u_slot_decode (
    .slot_code_i(a_slp_slot_ff),
    .hw_assigned_i(a_hw_assigned_i),
    .target_slot_o(a_target_slot),
    .disable_o(a_target_disable)
  );

  voltage_code_to_mv u_a_mv (
    .code_i(a_slp_vsel_ff),
    .mv_o(a_mv)
  );

  // The sleep step fires once, on the strobe of the matching timeslot.
  wire a_slot_hit;

  assign a_slot_hit = sleep_seq_i && timeslot_stb_i && !a_done_ff &&
                      (timeslot_i == a_target_slot);

  reg nxt_a_in_sleep;
  reg nxt_a_disabled;

  // A disable code turns the output off; otherwise sleep voltage and mode are applied.
  always @* begin
    nxt_a_in_sleep = a_in_sleep_o;
    nxt_a_disabled = a_disabled_o;
    if (wake_i) begin
      nxt_a_in_sleep = 1'b0;
      nxt_a_disabled = 1'b0;
    end else if (a_slot_hit) begin
      nxt_a_in_sleep = ~a_target_disable;
      nxt_a_disabled = a_target_disable;
    end
  end

  // ==========================================================================
  // Channel B hardware control decode
  reg b_hw_active;
  reg [4:0] b_vsel_pick;
  reg nxt_b_enable;
  reg nxt_b_low_power;
  wire [11:0] b_mv;

  // Source selection, voltage pick and hardware operating mode.
  always @* begin
    case (b_hwc_src_ff)
      `HWC_IN1: b_hw_active = hwc1_i;
      `HWC_IN2: b_hw_active = hwc2_i;
      `HWC_EITHER: b_hw_active = hwc1_i | hwc2_i;
      default: b_hw_active = 1'b0;
    endcase
    if (b_hw_active && b_hwc_vpick_ff) begin
      b_vsel_pick = b_slp_vsel_ff;
    end else begin
      b_vsel_pick = b_on_vsel_ff;
    end
    if (b_hw_active) begin
      case (b_hwc_mode_ff)
        `HMODE_OFF: begin
          nxt_b_enable = 1'b0;
          nxt_b_low_power = 1'b0;
        end
        `HMODE_ON_BIT: begin
          nxt_b_enable = 1'b1;
          nxt_b_low_power = b_on_mode_ff;
        end
        default: begin
          nxt_b_enable = 1'b1;
          nxt_b_low_power = 1'b1;
        end
      endcase
    end else begin
      nxt_b_enable = b_sw_on_i;
      nxt_b_low_power = b_on_mode_ff;
    end
    if (b_shutdown_ff) begin
      nxt_b_enable = 1'b0;
    end
  end

  voltage_code_to_mv u_b_mv (
    .code_i(b_vsel_pick),
    .mv_o(b_mv)
  );

  // ==========================================================================
  // Interrupt status
  reg [1:0] irq_events;
  reg [1:0] nxt_irq_status;

  // New events win over the clear that a status read performs.
  always @* begin
    irq_events = 2'h0;
    irq_events[`IRQ_UV_BIT] = b_undervoltage_i;
    irq_events[`IRQ_SLEEP_BIT] = a_slot_hit;
    if (rd_status) begin
      nxt_irq_status = irq_events;
    end else begin
      nxt_irq_status = irq_status_ff | irq_events;
    end
  end

  // ==========================================================================
  // Register writes
  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      a_slp_slot_ff <= `RST_SLP_SLOT;
      a_slp_mode_ff <= `RST_SLP_MODE;
      a_slp_vsel_ff <= `RST_VSEL;
      b_err_act_ff <= `RST_ERR_ACT;
      b_hwc_src_ff <= `RST_HWC_SRC;
      b_hwc_vpick_ff <= 1'b0;
      b_hwc_mode_ff <= `RST_HWC_MODE;
      b_flt_ff <= `RST_FLT;
      b_swi_ff <= 1'b0;
      b_lp_class_ff <= 1'b0;
      b_on_mode_ff <= 1'b0;
      b_on_vsel_ff <= `RST_VSEL;
      b_slp_vsel_ff <= `RST_VSEL;
      irq_mask_ff <= `RST_IRQ_MASK;
    end else begin
      if (wr_a_slp) begin
        a_slp_slot_ff <= wdata_i[`SLP_SLOT_MSB:`SLP_SLOT_LSB];
        a_slp_mode_ff <= wdata_i[`SLP_MODE_BIT];
        a_slp_vsel_ff <= wdata_i[`VSEL_MSB:`VSEL_LSB];
      end
      if (wr_b_main) begin
        b_err_act_ff <= wdata_i[`ERR_ACT_MSB:`ERR_ACT_LSB];
        b_hwc_src_ff <= wdata_i[`HWC_SRC_MSB:`HWC_SRC_LSB];
        b_hwc_vpick_ff <= wdata_i[`HWC_VPICK_BIT];
        b_hwc_mode_ff <= wdata_i[`HWC_MODE_MSB:`HWC_MODE_LSB];
        b_flt_ff <= wdata_i[`FLT_BIT];
        b_swi_ff <= wdata_i[`SWI_BIT];
        b_lp_class_ff <= wdata_i[`LP_CLASS_BIT];
      end
      if (wr_b_on) begin
        b_on_mode_ff <= wdata_i[`ON_MODE_BIT];
        b_on_vsel_ff <= wdata_i[`VSEL_MSB:`VSEL_LSB];
      end
      if (wr_b_slp) begin
        b_slp_vsel_ff <= wdata_i[`VSEL_MSB:`VSEL_LSB];
      end
      if (wr_mask) begin
        irq_mask_ff <= wdata_i[1:0];
      end
    end
  end

  // ==========================================================================
  // Undervoltage response
  // A regulator shutdown holds until software rewrites the main control register.
  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      b_shutdown_ff <= 1'b0;
      sys_reset_req_o <= 1'b0;
    end else begin
      sys_reset_req_o <= b_undervoltage_i && (b_err_act_ff == `ACT_SHUT_SYS);
      if (b_undervoltage_i && (b_err_act_ff == `ACT_SHUT_REG)) begin
        b_shutdown_ff <= 1'b1;
      end else if (wr_b_main) begin
        b_shutdown_ff <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Channel state outputs
  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      a_done_ff <= 1'b0;
      a_in_sleep_o <= 1'b0;
      a_disabled_o <= 1'b0;
      a_low_power_o <= 1'b0;
      a_sleep_mv_o <= `MV_BASE;
      b_enable_o <= 1'b0;
      b_low_power_o <= 1'b0;
      b_class_20ma_o <= 1'b0;
      b_discharge_o <= 1'b0;
      b_mv_o <= `MV_BASE;
    end else begin
      if (wake_i) begin
        a_done_ff <= 1'b0;
      end else if (a_slot_hit) begin
        a_done_ff <= 1'b1;
      end
      a_in_sleep_o <= nxt_a_in_sleep;
      a_disabled_o <= nxt_a_disabled;
      a_low_power_o <= nxt_a_in_sleep & a_slp_mode_ff;
      a_sleep_mv_o <= a_mv;
      b_enable_o <= nxt_b_enable;
      b_low_power_o <= nxt_b_low_power;
      b_class_20ma_o <= b_lp_class_ff;
      b_discharge_o <= ~nxt_b_enable & ~b_flt_ff;
      b_mv_o <= b_mv;
    end
  end

  // ==========================================================================
  // Interrupt status and output
  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      irq_status_ff <= 2'h0;
      irq_o <= 1'b0;
    end else begin
      irq_status_ff <= nxt_irq_status;
      irq_o <= |(nxt_irq_status & irq_mask_ff);
    end
  end

  // ==========================================================================
  // Read data
  reg [15:0] nxt_rdata;

  // Unmapped addresses and idle cycles read as zero.
  always @* begin
    nxt_rdata = 16'h0000;
    if (rd_i) begin
      case (addr_i)
        `OFS_A_SLEEP_CTRL: begin
          nxt_rdata[`SLP_SLOT_MSB:`SLP_SLOT_LSB] = a_slp_slot_ff;
          nxt_rdata[`SLP_MODE_BIT] = a_slp_mode_ff;
          nxt_rdata[`VSEL_MSB:`VSEL_LSB] = a_slp_vsel_ff;
        end
        `OFS_B_MAIN_CTRL: begin
          nxt_rdata[`ERR_ACT_MSB:`ERR_ACT_LSB] = b_err_act_ff;
          nxt_rdata[`HWC_SRC_MSB:`HWC_SRC_LSB] = b_hwc_src_ff;
          nxt_rdata[`HWC_VPICK_BIT] = b_hwc_vpick_ff;
          nxt_rdata[`HWC_MODE_MSB:`HWC_MODE_LSB] = b_hwc_mode_ff;
          nxt_rdata[`FLT_BIT] = b_flt_ff;
          nxt_rdata[`SWI_BIT] = b_swi_ff;
          nxt_rdata[`LP_CLASS_BIT] = b_lp_class_ff;
        end
        `OFS_B_ON_CTRL: begin
          nxt_rdata[`ON_MODE_BIT] = b_on_mode_ff;
          nxt_rdata[`VSEL_MSB:`VSEL_LSB] = b_on_vsel_ff;
        end
        `OFS_B_SLEEP_CTRL: begin
          nxt_rdata[`VSEL_MSB:`VSEL_LSB] = b_slp_vsel_ff;
        end
        `OFS_IRQ_STATUS: begin
          nxt_rdata[1:0] = irq_status_ff;
        end
        `OFS_IRQ_MASK: begin
          nxt_rdata[1:0] = irq_mask_ff;
        end
        default: begin
          nxt_rdata = 16'h0000;
        end
      endcase
    end
  end

  // Read data stands only in the cycle after the strobe.
  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      rdata_o <= 16'h0000;
    end else begin
      rdata_o <= nxt_rdata;
    end
  end

endmodule

// *** regulator_regs_chk_asserts.sv ***
// Concurrent assertions on the ports of the regulator control bank.
`timescale 1ns/1ps
// ==========================================================
// Port checker
module regulator_regs_chk (
  // Clock and reset.
  input wire sys_clk_i,
  input wire rst_i,
  // Observed inputs.
  input wire wake_i,
  input wire timeslot_stb_i,
  input wire a_hw_assigned_i,
  // Observed outputs.
  input wire a_in_sleep_o,
  input wire a_disabled_o,
  input wire a_low_power_o,
  input wire b_enable_o,
  input wire b_discharge_o,
  input wire [11:0] b_mv_o,
  input wire sys_reset_req_o
);
  // All checks sample on the rising edge and rest during reset.
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  // Sleep state of channel A.
  chk_lp_in_sleep: assert property (a_low_power_o |-> a_in_sleep_o)
    else $error("low power flag without sleep state");
  chk_sleep_excl: assert property (!(a_in_sleep_o && a_disabled_o))
    else $error("sleep and disabled both set");
  chk_sleep_cause: assert property ($rose(a_in_sleep_o) |-> $past(timeslot_stb_i))
    else $error("sleep state without slot step");
  chk_dis_cause: assert property ($rose(a_disabled_o) |->
      $past(timeslot_stb_i) && !$past(a_hw_assigned_i))
    else $error("disable without slot step or while assigned");
  chk_wake_clear: assert property (wake_i |=> !a_in_sleep_o && !a_disabled_o)
    else $error("wake did not clear sleep state");
  // Channel B output state.
  chk_discharge_off: assert property (b_discharge_o |-> !b_enable_o)
    else $error("discharge while enabled");
  chk_mv_range: assert property (b_mv_o >= 12'h384 && b_mv_o <= 12'hCE4)
    else $error("voltage out of range");
  chk_sysrst_pulse: assert property (sys_reset_req_o |=> !sys_reset_req_o)
    else $error("system reset request longer than one cycle");
endmodule

bind regulator_channel_control_regs regulator_regs_chk i_chk (.sys_clk_i(sys_clk_i),
  .rst_i(rst_i), .wake_i(wake_i), .timeslot_stb_i(timeslot_stb_i),
  .a_hw_assigned_i(a_hw_assigned_i), .a_in_sleep_o(a_in_sleep_o),
  .a_disabled_o(a_disabled_o), .a_low_power_o(a_low_power_o), .b_enable_o(b_enable_o),
  .b_discharge_o(b_discharge_o), .b_mv_o(b_mv_o), .sys_reset_req_o(sys_reset_req_o));

// *** tb_top.sv ***
// Self-checking testbench of the regulator control bank.
`timescale 1ns/1ps
// ==========================================================
// Testbench
module tb_top;
  // Stimulus, all driven from time zero.
  logic sys_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [15:0] addr_i = 16'h0000;
  logic [15:0] wdata_i = 16'h0000;
  logic wr_i = 1'b0, rd_i = 1'b0, sleep_seq_i = 1'b0, timeslot_stb_i = 1'b0;
  logic [2:0] timeslot_i = 3'h0;
  logic wake_i = 1'b0, a_hw_assigned_i = 1'b0, hwc1_i = 1'b0, hwc2_i = 1'b0;
  logic b_sw_on_i = 1'b0, b_undervoltage_i = 1'b0;
  // Design outputs.
  wire [15:0] rdata_o;
  wire [11:0] a_sleep_mv_o, b_mv_o;
  wire a_in_sleep_o, a_disabled_o, a_low_power_o, b_enable_o, b_low_power_o;
  wire b_class_20ma_o, b_discharge_o, sys_reset_req_o, irq_o;
  int bad_count = 0;
  int checks = 0;
  // Register model: offsets, stored bits and reset values.
  logic [15:0] ofs [0:4] = '{16'h4073, 16'h4074, 16'h4075, 16'h4076, 16'h40F1};
  logic [15:0] msk [0:4] = '{16'hE11F, 16'hDFC1, 16'h011F, 16'h001F, 16'h0003};
  logic [15:0] rv [0:4] = '{16'h0100, 16'h0200, 16'h0000, 16'h0000, 16'h0000};

  // The clock toggles every half period of 10 ns.
  always #10 sys_clk_i = ~sys_clk_i;

  regulator_channel_control_regs i_dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .sleep_seq_i(sleep_seq_i), .timeslot_i(timeslot_i), .timeslot_stb_i(timeslot_stb_i),
    .wake_i(wake_i), .a_hw_assigned_i(a_hw_assigned_i), .hwc1_i(hwc1_i), .hwc2_i(hwc2_i),
    .b_sw_on_i(b_sw_on_i), .b_undervoltage_i(b_undervoltage_i),
    .a_in_sleep_o(a_in_sleep_o), .a_disabled_o(a_disabled_o),
    .a_low_power_o(a_low_power_o), .a_sleep_mv_o(a_sleep_mv_o), .b_enable_o(b_enable_o),
    .b_low_power_o(b_low_power_o), .b_class_20ma_o(b_class_20ma_o),
    .b_discharge_o(b_discharge_o), .b_mv_o(b_mv_o), .sys_reset_req_o(sys_reset_req_o),
    .irq_o(irq_o));

  // Millivolts of a voltage code: fine steps up to 0Eh, coarse steps above.
  function automatic logic [11:0] mv(input logic [4:0] c);
    return (c <= 5'h0E) ? 12'h384 + 12'h032 * c : 12'h640 + 12'h064 * (c - 5'h0E);
  endfunction

  // Compares one result and counts it.
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One register write with a quiet cycle after it.
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge sys_clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge sys_clk_i);
    wr_i <= 1'b0;
  endtask

  // One register read, checked in the cycle after the strobe.
  task automatic rd(input logic [15:0] a, input logic [15:0] exp);
    @(posedge sys_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge sys_clk_i);
    rd_i <= 1'b0;
    #1 cmp(rdata_o, exp);
  endtask

  // Waits some edges and lets their updates land.
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask

  // Prints the counts and the verdict, then stops.
  task automatic conclude();
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Cuts a hang short.
  initial begin
    repeat (30000) @(posedge sys_clk_i);
    bad_count++;
    conclude();
  end

  // Main sequence.
  initial begin
    logic [15:0] d;
    logic [2:0] tgt;
    logic dis, act, en, seen;
    void'($urandom(93661));
    repeat (10) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    tick(1);
    cmp(b_mv_o, 16'h0384);
    for (int i = 0; i < 5; i++) rd(ofs[i], rv[i]);
    rd(16'h40F0, 16'h0000);
    for (int i = 0; i < 5; i++) begin
      d = $urandom;
      wr(ofs[i], d);
      rd(ofs[i], d & msk[i]);
    end
    wr(16'h4077, 16'hFFFF);
    rd(16'h4077, 16'h0000);
    $display("test registers done");
    for (int c = 0; c < 32; c++) begin
      wr(16'h4073, c[15:0]);
      tick(3);
      cmp(a_sleep_mv_o, mv(c[4:0]));
    end
    $display("test voltage codes done");
    wr(16'h40F1, 16'h0002);
    for (int k = 0; k < 16; k++) begin
      d = $urandom;
      tgt = (k[2:0] == 3'h0) ? 3'h5 : (k[2:0] == 3'h6) ? 3'h3 :
            (k[2:0] == 3'h7) ? 3'h1 : 3'h6 - k[2:0];
      dis = (k[2:0] inside {[1:5]}) && !k[3];
      wr(16'h4073, {k[2:0], 4'h0, d[0], 8'h00});
      a_hw_assigned_i <= k[3];
      sleep_seq_i <= 1'b1;
      for (int s = 1; s < 6; s++) begin
        @(posedge sys_clk_i);
        timeslot_i <= s[2:0];
        timeslot_stb_i <= 1'b1;
        @(posedge sys_clk_i);
        timeslot_stb_i <= 1'b0;
        tick(2);
        cmp(a_disabled_o, s >= tgt && dis);
        cmp(a_in_sleep_o, s >= tgt && !dis);
        cmp(a_low_power_o, s >= tgt && !dis && d[0]);
      end
      cmp(irq_o, 1'b1);
      rd(16'h40F0, 16'h0002);
      tick(2);
      cmp(irq_o, 1'b0);
      @(posedge sys_clk_i);
      sleep_seq_i <= 1'b0;
      wake_i <= 1'b1;
      @(posedge sys_clk_i);
      wake_i <= 1'b0;
      tick(2);
      cmp(a_in_sleep_o | a_disabled_o, 1'b0);
    end
    $display("test sleep slots done");
    for (int a = 0; a < 4; a++) begin
      wr(16'h40F1, {15'h0000, a != 3});
      wr(16'h4074, {a[1:0], 14'h0000});
      b_sw_on_i <= 1'b1;
      tick(3);
      @(posedge sys_clk_i);
      b_undervoltage_i <= 1'b1;
      @(posedge sys_clk_i);
      b_undervoltage_i <= 1'b0;
      seen = 1'b0;
      repeat (4) begin
        #1 seen = seen | sys_reset_req_o;
        @(posedge sys_clk_i);
      end
      #1 cmp(seen, a == 2);
      cmp(b_enable_o, a != 1);
      cmp(irq_o, a != 3);
      rd(16'h40F0, 16'h0001);
    end
    $display("test undervoltage done");
    for (int k = 0; k < 64; k++) begin
      d = $urandom;
      wr(16'h4075, {7'h00, d[8], 3'h0, d[4:0]});
      wr(16'h4076, {11'h000, d[13:9]});
      wr(16'h4074, {3'h0, k[5:4], d[10], k[1:0], d[7], 6'h00, d[0]});
      hwc1_i <= k[2];
      hwc2_i <= k[3];
      b_sw_on_i <= d[14];
      tick(3);
      act = (k[5:4] == 2'h1) ? k[2] : (k[5:4] == 2'h2) ? k[3] : (k[5:4] == 2'h3) && (k[2] | k[3]);
      en = act ? k[1:0] != 2'h1 : d[14];
      cmp(b_enable_o, en);
      if (en) cmp(b_low_power_o, (act && k[1:0] != 2'h3) ? 1'b1 : d[8]);
      cmp(b_mv_o, mv((act && d[10]) ? d[13:9] : d[4:0]));
      cmp(b_discharge_o, !en && !d[7]);
      cmp(b_class_20ma_o, d[0]);
    end
    $display("test hardware control done");
    conclude();
  end
endmodule
